// file: bench/ttw_line_window_asserts.sv
/* checker for ttw_line_window: bus handshake, request pin, line windows.
   assumes: bound to the top module; shadows ctrl and mode writes itself. */
`timescale 1ns/1ps
`default_nettype none
module ttw_line_window_asserts import ttw_pkg::*; #(
  parameter int unsigned PERIOD = BIT_PERIOD_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic strap_ntsc,
  input wire ttw_timing_t timing,
  input wire logic line_teletext_disable,
  input wire logic teletext_serial_data_input,
  input wire logic request_or_second_clock_pin,
  input wire logic request_line,
  input wire logic active_video,
  input wire logic teletext_bit,
  input wire logic teletext_bit_valid
);
  typedef struct packed {
    logic [7:0] ctl;
    logic [7:0] mode;
    logic [9:0] hi;
  } ttw_chk_t;
  ttw_chk_t st_q;
  ttw_chk_t st_d;
  wire logic pin = request_or_second_clock_pin;
  wire logic tick = timing.line_start | timing.field_sync;
  wire logic wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0];
  wire logic [9:0] leg_len = !st_q.ctl[1] ? 10'(BITS_EURO * PERIOD) :
    st_q.mode[7] ? 10'(BITS_WST60 * PERIOD) : 10'(BITS_NABTS * PERIOD);
  always_comb begin
    st_d = st_q;
    st_d.hi = pin ? st_q.hi + 10'h001 : 10'h000;
    if (wr && wb_adr_i[9:2] == IDX_CTRL) st_d.ctl = wb_dat_i[7:0];
    if (wr && wb_adr_i[9:2] == IDX_MODE) st_d.mode = wb_dat_i[7:0];
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) st_q <= {CTRL_RST, MODE_RST, 10'h000};
    else st_q <= st_d;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // shadow updates on the same edge as the design; the guards still look two cycles back
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  req_window_a: assert property ($rose(pin) && !st_q.ctl[0] && !$past(st_q.ctl[0], 2)
    |-> request_line) else $error("request outside window");
  clk2_toggle_a: assert property (st_d.ctl[0] && st_q.ctl[0] && $past(st_q.ctl[0], 2)
    |-> pin != $past(pin)) else $error("second clock not toggling");
  one_bit_a: assert property ($rose(pin) && !st_q.ctl[0] && !$past(st_q.ctl[0], 2)
    && !st_q.mode[5] |=> !pin) else $error("request pulse too long");
  data_delay_a: assert property ($rose(pin) && !st_q.ctl[0] && !$past(st_q.ctl[0], 2)
    && !st_q.mode[5] && st_q.ctl[7:4] == 4'h2 |-> ##3 teletext_bit_valid)
    else $error("bit not sampled");
  valid_cause_a: assert property (teletext_bit_valid && !st_q.mode[5] && !st_q.ctl[0]
    && st_q.ctl[7:4] == 4'h2 |-> $past(pin, 3) && !$past(pin, 4))
    else $error("bit without request edge");
  legacy_len_a: assert property ($fell(pin) && st_q.mode[5] && !st_q.ctl[0]
    && !$past(st_q.ctl[0], 2) |-> st_q.hi == leg_len) else $error("window length wrong");
  lines_stable_a: assert property (!tick && !$past(tick) && !$past(tick, 2)
    && !$past(tick, 3) && !$past(wb_ack_o) && !$past(wb_ack_o, 2) && !$past(wb_ack_o, 3)
    |-> $stable(request_line) && $stable(active_video)) else $error("line flag moved");
endmodule // ttw_line_window_asserts
bind ttw_line_window ttw_line_window_asserts #(.PERIOD(PERIOD)) i_chk (.clk(clk),
  .reset_n(reset_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .strap_ntsc(strap_ntsc), .timing(timing),
  .line_teletext_disable(line_teletext_disable),
  .teletext_serial_data_input(teletext_serial_data_input),
  .request_or_second_clock_pin(request_or_second_clock_pin), .request_line(request_line),
  .active_video(active_video), .teletext_bit(teletext_bit),
  .teletext_bit_valid(teletext_bit_valid));
`default_nettype wire

// file: bench/ttw_line_window_test.sv
/* testbench for ttw_line_window: registers, windows, protocols, clock out.
   assumes: the source model on the serial input; 10 MHz clock. */
`timescale 1ns/1ps
`default_nettype none
module ttw_line_window_test import ttw_pkg::*;;
  logic clk;
  logic rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, strap = 1'b0, dis = 1'b0;
  logic [9:0] adr = 10'h000;
  logic [3:0] sel = 4'hF;
  logic [31:0] wd = 32'h0, rd;
  logic ack, pin, rl, av, tb, tv, sd;
  ttw_timing_t tm = 3'h0;
  int error_cnt = 0, cmp_count = 0, cyc_n = 0;
  logic [7:0] rv [2][8] = '{'{8'h05, 8'h16, 8'h04, 8'h16, 8'h00, 8'h00, 8'h00, 8'h20},
    '{8'h06, 8'h10, 8'h05, 8'h10, 8'h00, 8'h00, 8'h00, 8'h20}};
  logic [7:0] c2 [8] = '{8'h03, 8'h06, 8'h06, 8'h07, 8'h02, 8'h04, 8'h00, 8'h20};
  logic [7:0] c3 [8] = '{8'h01, 8'h03, 8'h02, 8'h04, 8'h00, 8'h03, 8'h21, 8'h22};
  ttw_line_window #(.PERIOD(2)) i_dut (.clk(clk), .reset_n(rst_n), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd),
    .wb_dat_o(rd), .wb_ack_o(ack), .strap_ntsc(strap), .timing(tm),
    .line_teletext_disable(dis), .teletext_serial_data_input(sd),
    .request_or_second_clock_pin(pin), .request_line(rl), .active_video(av),
    .teletext_bit(tb), .teletext_bit_valid(tv));
  ttw_source_model i_src (.clk(clk), .rst_n(rst_n), .req(pin),
    .line_tick(tm.line_start | tm.field_sync), .data(sd));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic test_done;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc_n++;
    if (cyc_n == 70000) begin
      error_cnt++;
      test_done();
    end
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] i, input logic [7:0] d,
      output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk);
    {cyc, stb, we, adr, wd} <= {2'b11, w, i, 2'b00, 24'h0, d};
    // ack and read data taken at the rising edge; only the global limit ends a hang
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1);
    r = rd;
    {cyc, stb, we} <= 3'b000;
    chk("ack wait", n, 2);
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    logic [31:0] r;
    xfer(1'b1, i, d, r);
  endtask
  task automatic rdc(input logic [7:0] i, input logic [31:0] e);
    logic [31:0] r;
    xfer(1'b0, i, 8'h00, r);
    chk("register", r, e);
  endtask
  // one field of nine lines; masks of lines with request edges and active video
  task automatic fld(input logic odd, input int dl, input logic cb, output logic [15:0] pm,
      output logic [15:0] am, output int nr);
    int v;
    logic pv;
    {pm, am, nr} = '0;
    @(posedge clk);
    {tm, dis} <= {2'b01, odd, 1'b0};
    for (int l = 1; l < 10; l++) begin
      @(posedge clk);
      tm <= {2'b00, odd};
      {v, pv} = '0;
      repeat (730) begin
        @(negedge clk);
        if (pin && !pv) {pm[l], nr} = {1'b1, nr + 1};
        pv = pin;
        if (cb && tv) begin
          chk("bit", tb, v[0]);
          v++;
        end
      end
      am[l] = av;
      if (l != dl) chk("window flag", rl, pm[l]);
      @(posedge clk);
      {tm, dis} <= {2'b10, odd, l + 1 == dl};
    end
    // the line ten tick must not stay up into the next accesses
    @(posedge clk);
    tm <= {2'b00, odd};
  endtask
  initial begin
    logic [15:0] pm, am;
    int nr, n;
    logic pv;
    for (int s = 0; s < 2; s++) begin
      strap <= s[0];
      rst_n <= 1'b0;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      for (int i = 0; i < 8; i++) rdc(8'h76 + i[7:0], rv[s][i]);
    end
    rdc(8'h90, 32'h0);
    $display("test reset values done");
    for (int i = 0; i < 8; i++) wr(8'h76 + i[7:0], c2[i]);
    rdc(8'h77, 32'h06);
    fld(1'b1, 5, 1'b1, pm, am, nr);
    chk("odd lines", pm, 16'h0050);
    chk("odd active", am, 16'h0018);
    chk("bit count", nr, 720);
    rdc(IDX_STATUS, 32'h20A);
    fld(1'b0, 3, 1'b1, pm, am, nr);
    chk("even lines", pm, 16'h0080);
    $display("test other system done");
    for (int i = 0; i < 8; i++) wr(8'h76 + i[7:0], c3[i]);
    for (int m = 0; m < 2; m++) begin
      wr(IDX_MODE, {m[0], 7'h21});
      fld(1'b1, 0, 1'b0, pm, am, nr);
      chk("m odd lines", pm, 16'h0000);
      chk("m active", am, 16'h007E);
      fld(1'b0, 0, 1'b0, pm, am, nr);
      chk("m even lines", pm, 16'h00C0);
    end
    $display("test m system legacy done");
    wr(IDX_CTRL, 8'h21);
    repeat (4) @(negedge clk);
    {n, pv} = {32'd0, pin};
    repeat (20) begin
      @(negedge clk);
      n += int'(pin !== pv);
      pv = pin;
    end
    chk("clock out", n, 20);
    wr(IDX_CTRL, 8'h20);
    repeat (4) @(negedge clk);
    chk("pin idle", pin, 1'b0);
    $display("test second clock done");
    test_done();
  end
endmodule // ttw_line_window_test
`default_nettype wire

// file: bench/ttw_source_model.sv
/* teletext source model: one bit per request edge, index restarts per line.
   assumes: request from the pin, line tick from encoder timing. */
`timescale 1ns/1ps
`default_nettype none
module ttw_source_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req,
  input wire logic line_tick,
  output logic data
);
  logic pv;
  logic hold;
  logic [8:0] k;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pv <= 1'b0;
      hold <= 1'b0;
      k <= 9'h000;
      data <= 1'b0;
    end else begin
      pv <= req;
      hold <= 1'b0;
      if (line_tick) k <= 9'h000;
      if (req && !pv) begin
        data <= k[0];
        k <= k + 9'h001;
        hold <= 1'b1;
      end else if (!hold) data <= ~data; // stale bit never looks valid
    end
  end
endmodule // ttw_source_model
`default_nettype wire

// file: rtl/ttw_line_window.sv
/*
  ttw_line_window: vertical teletext request window and active video line
  window of a video encoder, with its registers on classic wishbone.
  assumes: line_start and field_sync pulses come from the encoder timing,
  synchronous to clk; strap_ntsc is stable around reset release.
*/
// Functional notes
// - odd first request line adds 4 or 1
// - odd last request line adds 3 or 0
// - even first request line adds 4 or 1
// - even last request line adds 3 or 0
// - request on pin only when clk2 disabled
// - first active line adds 4 or 1, bit8=mode4
// - last active line adds 3 or 0, bit8=mode6
// - zero active boundary sits at field sync
// - mode bit 7 picks teletext standard in M system (ctrl bit 1 set), else euro
// - new protocol: one bit per rising edge
// - legacy protocol: one high window per line
// - line disable only inside request windows
`timescale 1ns/1ps
`default_nettype none
module ttw_line_window import ttw_pkg::*; #(
  parameter int unsigned PERIOD = BIT_PERIOD_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic strap_ntsc,
  input wire ttw_timing_t timing,
  input wire logic line_teletext_disable,
  input wire logic teletext_serial_data_input,
  output logic request_or_second_clock_pin,
  output logic request_line,
  output logic active_video,
  output logic teletext_bit,
  output logic teletext_bit_valid
);

  localparam logic [6:0][7:0] REGS_RST_PAL = {MODE_RST, LAST_ACTIVE_RST, FIRST_ACTIVE_RST,
    EVEN_END_PAL, EVEN_START_PAL, ODD_END_PAL, ODD_START_PAL};
  localparam logic [6:0][7:0] REGS_RST_NTSC = {MODE_RST, LAST_ACTIVE_RST, FIRST_ACTIVE_RST,
    EVEN_END_NTSC, EVEN_START_NTSC, ODD_END_NTSC, ODD_START_NTSC};

  typedef struct packed {
    logic strap_done;
    logic ack;
    logic [11:0] rdata;
    logic [6:0][7:0] regs;
    logic [7:0] ctrl;
    logic [8:0] line;
    logic odd;
    logic in_window;
    logic active;
    logic clk2;
  } ttw_state_t;

  ttw_state_t s_q, s_d;
  logic [1:0] rst_sync_q;
  logic rst_n;

  // reset released through two flops so all state leaves reset together
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  function automatic logic [9:0] line_at(input logic [8:0] v, input logic [2:0] add);
    line_at = {1'b0, v} + {7'h00, add};
  endfunction

  function automatic logic [9:0] active_at(input logic [8:0] v, input logic [2:0] add);
    if (v == 9'h000) begin
      active_at = FIELD_SYNC_LINE;
    end else begin
      active_at = line_at(v, add);
    end
  endfunction

  function automatic logic is_line_reg(input logic [7:0] idx);
    is_line_reg = (idx >= IDX_ODD_START) && (idx <= IDX_MODE);
  endfunction

  logic [7:0] idx;
  logic [2:0] reg_sel;
  logic [7:0] mode;
  logic msys;
  logic [8:0] odd_first_v, odd_last_v, even_first_v, even_last_v;
  logic [8:0] first_v, last_v;
  logic [9:0] odd_first, odd_last, even_first, even_last;
  logic [9:0] first_line, last_line;
  logic [8:0] next_line;
  logic next_odd;
  logic line_tick;
  logic [9:0] win_first, win_last;
  logic next_in_window;
  logic start_req;
  ttw_gen_cfg_t gen_cfg;
  logic gen_request;

  assign idx = wb_adr_i[9:2];
  assign reg_sel = 3'(idx - IDX_ODD_START);
  assign mode = s_q.regs[6];
  assign msys = s_q.ctrl[CTRL_RATE_SEL_BIT];

  // ninth bits live in the mode register
  assign odd_first_v = {mode[MODE_ODD_START_BIT8], s_q.regs[0]};
  assign odd_last_v = {mode[MODE_ODD_END_BIT8], s_q.regs[1]};
  assign even_first_v = {mode[MODE_EVEN_START_BIT8], s_q.regs[2]};
  assign even_last_v = {mode[MODE_EVEN_END_BIT8], s_q.regs[3]};
  assign first_v = {mode[MODE_FIRST_BIT8], s_q.regs[4]};
  assign last_v = {mode[MODE_LAST_BIT8], s_q.regs[5]};

  assign odd_first = line_at(odd_first_v, msys ? M_START_ADD : O_START_ADD);
  assign odd_last = line_at(odd_last_v, msys ? M_END_ADD : O_END_ADD);
  assign even_first = line_at(even_first_v, msys ? M_START_ADD : O_START_ADD);
  assign even_last = line_at(even_last_v, msys ? M_END_ADD : O_END_ADD);
  assign first_line = active_at(first_v, msys ? M_START_ADD : O_START_ADD);
  assign last_line = active_at(last_v, msys ? M_END_ADD : O_END_ADD);

  // line numbering restarts at the field sync pulse
  assign line_tick = timing.field_sync || timing.line_start;
  assign next_line = timing.field_sync ? 9'h001 : (s_q.line + 9'h001);
  assign next_odd = timing.field_sync ? timing.odd_field : s_q.odd;

  assign win_first = next_odd ? odd_first : even_first;
  assign win_last = next_odd ? odd_last : even_last;
  assign next_in_window = ({1'b0, next_line} >= win_first) &&
    ({1'b0, next_line} <= win_last);

  // the disable input can only remove lines already inside a window
  assign start_req = line_tick && next_in_window && !line_teletext_disable;

  always_comb begin
    gen_cfg.legacy = mode[MODE_LEGACY_BIT];
    gen_cfg.delay = s_q.ctrl[CTRL_DELAY_LSB +: 4];
    if (!msys) begin
      gen_cfg.bits = BITS_EURO;
    end else if (mode[MODE_WST60_BIT]) begin
      gen_cfg.bits = BITS_WST60;
    end else begin
      gen_cfg.bits = BITS_NABTS;
    end
  end

  always_comb begin
    s_d = s_q;
    s_d.clk2 = !s_q.clk2;
    // strap caught once, on the first cycle after reset release
    if (!s_q.strap_done) begin
      s_d.strap_done = 1'b1;
      s_d.regs = strap_ntsc ? REGS_RST_NTSC : REGS_RST_PAL;
    end
    if (line_tick) begin
      s_d.line = next_line;
      s_d.odd = next_odd;
      s_d.in_window = next_in_window;
      s_d.active = ({1'b0, next_line} >= first_line) && ({1'b0, next_line} <= last_line);
    end
    // ack one cycle after the request, dropped the cycle after
    s_d.ack = wb_cyc_i && wb_stb_i && !s_q.ack;
    if (s_d.ack) begin
      if (is_line_reg(idx)) begin
        s_d.rdata = {4'h0, s_q.regs[reg_sel]};
      end else if (idx == IDX_CTRL) begin
        s_d.rdata = {4'h0, s_q.ctrl};
      end else if (idx == IDX_STATUS) begin
        s_d.rdata = {s_q.active, s_q.in_window, s_q.odd, s_q.line};
      end else begin
        s_d.rdata = 12'h000;
      end
    end
    // writes land on the edge at which the master sees ack
    if (s_q.ack && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0]) begin
      if (is_line_reg(idx)) begin
        s_d.regs[reg_sel] = wb_dat_i[7:0];
      end else if (idx == IDX_CTRL) begin
        s_d.ctrl = wb_dat_i[7:0];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{regs: REGS_RST_PAL, ctrl: CTRL_RST, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  ttw_req_gen #(
    .PERIOD(PERIOD)
  ) u_gen (
    .clk(clk),
    .rst_n(rst_n),
    .start(start_req),
    .cfg(gen_cfg),
    .serial_in(teletext_serial_data_input),
    .request(gen_request),
    .bit_out(teletext_bit),
    .bit_valid(teletext_bit_valid)
  );

  // pin is shared; the divided clock wins when enabled
  assign request_or_second_clock_pin = s_q.ctrl[CTRL_CLK2_OUT_BIT] ? s_q.clk2 : gen_request;
  assign request_line = s_q.in_window;
  assign active_video = s_q.active;
  assign wb_ack_o = s_q.ack;
  assign wb_dat_o = {20'h00000, s_q.rdata};

endmodule // ttw_line_window
`default_nettype wire

// file: rtl/ttw_pkg.sv
/*
  ttw_pkg: constants, field layouts, reset values and carrier types for the
  teletext request line window block.
  assumes: a single 10 MHz clock and a classic wishbone register port.
*/
package ttw_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_ODD_START = 8'h76;
  localparam logic [7:0] IDX_ODD_END = 8'h77;
  localparam logic [7:0] IDX_EVEN_START = 8'h78;
  localparam logic [7:0] IDX_EVEN_END = 8'h79;
  localparam logic [7:0] IDX_FIRST_ACTIVE = 8'h7A;
  localparam logic [7:0] IDX_LAST_ACTIVE = 8'h7B;
  localparam logic [7:0] IDX_MODE = 8'h7C;
  localparam logic [7:0] IDX_CTRL = 8'h7D;
  localparam logic [7:0] IDX_STATUS = 8'h80;
  localparam int unsigned NUM_LINE_REGS = 7;

  // reset values, strap dependent where two are given
  localparam logic [7:0] ODD_START_PAL = 8'h05;
  localparam logic [7:0] ODD_START_NTSC = 8'h06;
  localparam logic [7:0] ODD_END_PAL = 8'h16;
  localparam logic [7:0] ODD_END_NTSC = 8'h10;
  localparam logic [7:0] EVEN_START_PAL = 8'h04;
  localparam logic [7:0] EVEN_START_NTSC = 8'h05;
  localparam logic [7:0] EVEN_END_PAL = 8'h16;
  localparam logic [7:0] EVEN_END_NTSC = 8'h10;
  localparam logic [7:0] FIRST_ACTIVE_RST = 8'h00;
  localparam logic [7:0] LAST_ACTIVE_RST = 8'h00;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h20;

  // mode register bits
  localparam int unsigned MODE_WST60_BIT = 7;
  localparam int unsigned MODE_LAST_BIT8 = 6;
  localparam int unsigned MODE_LEGACY_BIT = 5;
  localparam int unsigned MODE_FIRST_BIT8 = 4;
  localparam int unsigned MODE_EVEN_END_BIT8 = 3;
  localparam int unsigned MODE_ODD_END_BIT8 = 2;
  localparam int unsigned MODE_EVEN_START_BIT8 = 1;
  localparam int unsigned MODE_ODD_START_BIT8 = 0;

  // control register bits
  localparam int unsigned CTRL_CLK2_OUT_BIT = 0;
  localparam int unsigned CTRL_RATE_SEL_BIT = 1;
  localparam int unsigned CTRL_DELAY_LSB = 4;

  // line offsets added to programmed values
  localparam logic [2:0] M_START_ADD = 3'h4;
  localparam logic [2:0] O_START_ADD = 3'h1;
  localparam logic [2:0] M_END_ADD = 3'h3;
  localparam logic [2:0] O_END_ADD = 3'h0;
  localparam logic [9:0] FIELD_SYNC_LINE = 10'h001;

  // request bits per line for each standard; plain defaults
  localparam logic [8:0] BITS_EURO = 9'h168;
  localparam logic [8:0] BITS_NABTS = 9'h120;
  localparam logic [8:0] BITS_WST60 = 9'h128;
  localparam int unsigned BIT_PERIOD_CYC = 2;

  typedef struct packed {
    logic line_start;
    logic field_sync;
    logic odd_field;
  } ttw_timing_t;

  typedef struct packed {
    logic legacy;
    logic [8:0] bits;
    logic [3:0] delay;
  } ttw_gen_cfg_t;

  typedef enum logic [0:0] {
    GEN_IDLE = 1'b0,
    GEN_RUN = 1'b1
  } ttw_gen_state_t;

endpackage

// file: rtl/ttw_req_gen.sv
/*
  ttw_req_gen: produces the teletext request waveform for one line and
  samples the serial data returned by the teletext source.
  assumes: start is a one-cycle pulse; serial input is synchronous.
*/
`timescale 1ns/1ps
`default_nettype none
module ttw_req_gen import ttw_pkg::*; #(
  parameter int unsigned PERIOD = BIT_PERIOD_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire ttw_gen_cfg_t cfg,
  input wire logic serial_in,
  output logic request,
  output logic bit_out,
  output logic bit_valid
);

  typedef struct packed {
    ttw_gen_state_t st;
    logic [7:0] cnt;
    logic [8:0] left;
    logic req;
    logic [15:0] rise_sr;
    logic bit_v;
    logic bit_d;
  } ttw_gen_reg_t;

  ttw_gen_reg_t s_q, s_d;
  logic req_next;

  always_comb begin
    s_d = s_q;
    req_next = 1'b0;
    s_d.bit_v = 1'b0;
    case (s_q.st)
      GEN_IDLE: begin
        if (start && cfg.bits != 9'h000) begin
          s_d.st = GEN_RUN;
          s_d.cnt = 8'h00;
          s_d.left = cfg.bits;
          req_next = 1'b1;
        end
      end
      GEN_RUN: begin
        if (s_q.cnt == 8'(PERIOD - 1)) begin
          s_d.cnt = 8'h00;
          s_d.left = s_q.left - 9'h001;
          if (s_q.left == 9'h001) begin
            s_d.st = GEN_IDLE;
          end else begin
            req_next = 1'b1;
          end
        end else begin
          s_d.cnt = s_q.cnt + 8'h01;
          // legacy holds high through the window; new mode gives one edge per bit
          req_next = cfg.legacy || (s_d.cnt < 8'(PERIOD / 2));
        end
      end
      default: begin
        s_d.st = GEN_IDLE;
      end
    endcase
    // new protocol returns low between bits, so each bit owns a rising edge
    if (!cfg.legacy && s_q.st == GEN_RUN && s_d.cnt == 8'h00 && PERIOD < 2) begin
      req_next = 1'b0;
    end
    s_d.req = req_next;
    s_d.rise_sr = {s_q.rise_sr[14:0], req_next && (!s_q.req || s_d.cnt == 8'h00)};
    // source answers a programmed count of cycles after each rising edge
    if (s_q.rise_sr[cfg.delay]) begin
      s_d.bit_v = 1'b1;
      s_d.bit_d = serial_in;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{st: GEN_IDLE, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign request = s_q.req;
  assign bit_out = s_q.bit_d;
  assign bit_valid = s_q.bit_v;

endmodule // ttw_req_gen
`default_nettype wire
